// ### common/tgd_pkg.sv
// Purpose: Shared constants and types of the tap gesture detector.
// Assumes: 20 MHz system clock, 8-bit register port.
// Notes: Acceleration magnitude LSB is 1/32 g per axis.
package tgd_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 500000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_PIN_CTRL = 8'h22;
  localparam logic [7:0] ADDR_TAP_CFG = 8'h38;
  localparam logic [7:0] ADDR_TAP_STATUS = 8'h39;
  localparam logic [7:0] ADDR_THR_XY = 8'h3b;
  localparam logic [7:0] ADDR_THR_Z = 8'h3c;
  localparam logic [7:0] ADDR_DUR_LIMIT = 8'h3d;
  localparam logic [7:0] ADDR_LATENCY = 8'h3e;
  localparam logic [7:0] ADDR_WINDOW = 8'h3f;

  localparam logic [7:0] RST_REG = 8'h00;
  localparam int CFG_LATCH_BIT = 6;
  localparam int STS_ACTIVE_BIT = 6;
  localparam int THR_Y_LSB = 4;
  localparam int THR_X_LSB = 0;
  localparam int THR_Z_LSB = 0;
  localparam logic [7:0] ACC_PER_THR_STEP = 8'h10;

  localparam logic [2:0] SEL_GND = 3'h0;
  localparam logic [2:0] SEL_WAKE_ONE = 3'h1;
  localparam logic [2:0] SEL_WAKE_TWO = 3'h2;
  localparam logic [2:0] SEL_WAKE_ANY = 3'h3;
  localparam logic [2:0] SEL_DATA_READY = 3'h4;
  localparam logic [2:0] SEL_TAP = 3'h7;

  typedef enum logic [2:0] {
    AX_IDLE = 3'b000,
    AX_FIRST = 3'b001,
    AX_LATENCY = 3'b010,
    AX_WINDOW = 3'b011,
    AX_SECOND = 3'b100,
    AX_WAIT_LOW = 3'b101
  } tgd_axis_state_t;

  typedef struct packed {
    logic irq_polarity;
    logic irq_drive_type;
    logic [2:0] pin2_source_select;
    logic [2:0] pin1_source_select;
  } tgd_pin_ctrl_t;

  typedef struct packed {
    logic wakeup_source_one;
    logic wakeup_source_two;
    logic data_ready;
    logic tap_irq;
  } tgd_irq_src_t;

  typedef struct packed {
    logic [7:0] z;
    logic [7:0] y;
    logic [7:0] x;
  } tgd_accel_t;

endpackage : tgd_pkg

// ### hw/tgd_tick_gen.sv
// Purpose: Fixed 0.5 ms timebase for all tap timing.
// Assumes: TICK_CYCLES of at least 2.
// Notes: Independent of the output data rate.
`timescale 1ns/1ps
`default_nettype none
module tgd_tick_gen #(
  parameter int TICK_CYCLES = tgd_pkg::TICK_CYCLES
) (
  input wire logic clk_i,      // System clock
  input wire logic reset_n_i,  // Async reset, active low
  output logic tick_o          // One-cycle pulse every tick
);
  import tgd_pkg::*;

  localparam logic [15:0] LAST = 16'(TICK_CYCLES - 1);

  logic [15:0] cnt_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule : tgd_tick_gen
`default_nettype wire

// ### hw/tgd_irq_pin.sv
// Purpose: One interrupt pin: source mux, polarity and drive type.
// Assumes: Sources are levels synchronous to clk_i.
// Notes: Output enable is low while the pin is driven.
`timescale 1ns/1ps
`default_nettype none
module tgd_irq_pin (
  input wire logic clk_i,                  // System clock
  input wire logic reset_n_i,              // Async reset, active low
  input wire logic [2:0] sel_i,            // Source select code
  input wire logic polarity_i,             // 1: active low
  input wire logic drive_i,                // 1: open drain
  input wire tgd_pkg::tgd_irq_src_t src_i, // Candidate sources
  output logic pin_o,                      // Pad output value
  output logic pin_oe_n_o                  // Pad drive enable, low drives
);
  import tgd_pkg::*;

  logic active;
  logic level;

  always_comb begin
    if (sel_i == SEL_GND) begin
      active = 1'b0;
    end else if (sel_i == SEL_WAKE_ONE) begin
      active = src_i.wakeup_source_one;
    end else if (sel_i == SEL_WAKE_TWO) begin
      active = src_i.wakeup_source_two;
    end else if (sel_i == SEL_WAKE_ANY) begin
      active = src_i.wakeup_source_one | src_i.wakeup_source_two;
    end else if (sel_i == SEL_DATA_READY) begin
      active = src_i.data_ready;
    end else if (sel_i == SEL_TAP) begin
      active = src_i.tap_irq;
    end else begin
      active = 1'b0;
    end
    level = active ^ polarity_i;
  end

  // Open drain only ever pulls low; a high level is a release
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b0;
    end else if (drive_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= level;
    end else begin
      pin_o <= level;
      pin_oe_n_o <= 1'b0;
    end
  end

endmodule : tgd_irq_pin
`default_nettype wire

// ### hw/tgd_top.sv
// Purpose: Single and double tap detection on three axes with pins.
// Assumes: Register port strobes and accel inputs sync to clk_i.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module tgd_top #(
  parameter int TICK_CYCLES = tgd_pkg::TICK_CYCLES
) (
  input wire logic clk_i,                 // System clock, 20 MHz
  input wire logic reset_n_i,             // Async reset, active low
  input wire logic [7:0] reg_addr_i,      // Register address
  input wire logic reg_wr_i,              // Write strobe, one cycle
  input wire logic reg_rd_i,              // Read strobe, one cycle
  input wire logic [7:0] reg_wdata_i,     // Write data
  output logic [7:0] reg_rdata_o,         // Read data, next cycle
  input wire tgd_pkg::tgd_accel_t accel_i,// Per-axis magnitudes
  input wire logic wakeup_one_i,          // Wake-up source one
  input wire logic wakeup_two_i,          // Wake-up source two
  input wire logic data_ready_i,          // Data ready level
  output logic irq_pin_one_o,             // Pin one output value
  output logic irq_pin_one_oe_n_o,        // Pin one drive, low drives
  output logic irq_pin_two_o,             // Pin two output value
  output logic irq_pin_two_oe_n_o         // Pin two drive, low drives
);
  import tgd_pkg::*;

  // Threshold code to magnitude; code 0 fires on any nonzero input
  function automatic logic tgd_above(input logic [7:0] mag,
                                     input logic [3:0] thr);
    logic [11:0] lim;
    lim = 12'(thr) * 12'(ACC_PER_THR_STEP);
    tgd_above = 12'(mag) > lim;
  endfunction : tgd_above

  // Millisecond register steps count two ticks each
  function automatic logic [9:0] tgd_ms_ticks(input logic [7:0] val);
    tgd_ms_ticks = {1'b0, val, 1'b0};
  endfunction : tgd_ms_ticks

  tgd_pin_ctrl_t pin_ctrl_r;
  logic [7:0] tap_cfg_r;
  logic [7:0] thr_xy_r;
  logic [7:0] thr_z_r;
  logic [7:0] dur_r;
  logic [7:0] lat_r;
  logic [7:0] win_r;
  logic [5:0] flags_r;
  logic [5:0] flags_nxt;
  logic active_r;
  logic active_nxt;
  logic [9:0] hold_r;
  logic [9:0] hold_nxt;

  tgd_axis_state_t state_r [3];
  tgd_axis_state_t state_nxt [3];
  logic [9:0] cnt_r [3];
  logic [9:0] cnt_nxt [3];
  logic [2:0] single_ev;
  logic [2:0] double_ev;

  logic tick;
  logic latch_request;
  logic status_rd;
  logic enabled_ev;
  logic [7:0] mag [3];
  logic [3:0] thr [3];
  tgd_irq_src_t irq_src;

  assign latch_request = tap_cfg_r[CFG_LATCH_BIT];
  assign status_rd = reg_rd_i && (reg_addr_i == ADDR_TAP_STATUS);

  always_comb begin
    mag[0] = accel_i.x;
    mag[1] = accel_i.y;
    mag[2] = accel_i.z;
    thr[0] = thr_xy_r[THR_X_LSB +: 4];
    thr[1] = thr_xy_r[THR_Y_LSB +: 4];
    thr[2] = thr_z_r[THR_Z_LSB +: 4];
  end

  tgd_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_o(tick)
  );

  // Register writes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_ctrl_r <= tgd_pin_ctrl_t'(RST_REG);
      tap_cfg_r <= RST_REG;
      thr_xy_r <= RST_REG;
      thr_z_r <= RST_REG;
      dur_r <= RST_REG;
      lat_r <= RST_REG;
      win_r <= RST_REG;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_PIN_CTRL) begin
        pin_ctrl_r <= tgd_pin_ctrl_t'(reg_wdata_i);
      end else if (reg_addr_i == ADDR_TAP_CFG) begin
        tap_cfg_r <= {1'b0, reg_wdata_i[6:0]};
      end else if (reg_addr_i == ADDR_THR_XY) begin
        thr_xy_r <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_THR_Z) begin
        thr_z_r <= {4'h0, reg_wdata_i[3:0]};
      end else if (reg_addr_i == ADDR_DUR_LIMIT) begin
        dur_r <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_LATENCY) begin
        lat_r <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_WINDOW) begin
        win_r <= reg_wdata_i;
      end
    end
  end

  // Register reads, unmapped addresses return zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ADDR_PIN_CTRL) begin
        reg_rdata_o <= pin_ctrl_r;
      end else if (reg_addr_i == ADDR_TAP_CFG) begin
        reg_rdata_o <= tap_cfg_r;
      end else if (reg_addr_i == ADDR_TAP_STATUS) begin
        reg_rdata_o <= {1'b0, active_r, flags_r};
      end else if (reg_addr_i == ADDR_THR_XY) begin
        reg_rdata_o <= thr_xy_r;
      end else if (reg_addr_i == ADDR_THR_Z) begin
        reg_rdata_o <= thr_z_r;
      end else if (reg_addr_i == ADDR_DUR_LIMIT) begin
        reg_rdata_o <= dur_r;
      end else if (reg_addr_i == ADDR_LATENCY) begin
        reg_rdata_o <= lat_r;
      end else if (reg_addr_i == ADDR_WINDOW) begin
        reg_rdata_o <= win_r;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // Per-axis detection sequence
  always_comb begin
    logic above;
    logic dbl_en;
    above = 1'b0;
    dbl_en = 1'b0;
    single_ev = 3'b000;
    double_ev = 3'b000;
    for (int a = 0; a < 3; a++) begin
      state_nxt[a] = state_r[a];
      cnt_nxt[a] = cnt_r[a];
      above = tgd_above(mag[a], thr[a]);
      dbl_en = tap_cfg_r[2 * a + 1];
      case (state_r[a])
        AX_IDLE: begin
          if (above) begin
            state_nxt[a] = AX_FIRST;
            cnt_nxt[a] = 10'h000;
          end
        end
        AX_FIRST, AX_SECOND: begin
          if (!above) begin
            cnt_nxt[a] = 10'h000;
            if (state_r[a] == AX_SECOND) begin
              double_ev[a] = 1'b1;
              state_nxt[a] = AX_IDLE;
            end else begin
              single_ev[a] = 1'b1;
              // Only arm the second tap when double is wanted
              state_nxt[a] = dbl_en ? AX_LATENCY : AX_IDLE;
            end
          end else if (tick) begin
            if (cnt_r[a] >= {2'b00, dur_r}) begin
              state_nxt[a] = AX_WAIT_LOW;
            end else begin
              cnt_nxt[a] = cnt_r[a] + 10'h001;
            end
          end
        end
        AX_LATENCY: begin
          if (cnt_r[a] >= tgd_ms_ticks(lat_r)) begin
            state_nxt[a] = AX_WINDOW;
            cnt_nxt[a] = 10'h000;
          end else if (tick) begin
            cnt_nxt[a] = cnt_r[a] + 10'h001;
          end
        end
        AX_WINDOW: begin
          if (above) begin
            state_nxt[a] = AX_SECOND;
            cnt_nxt[a] = 10'h000;
          end else if (cnt_r[a] >= tgd_ms_ticks(win_r)) begin
            state_nxt[a] = AX_IDLE;
          end else if (tick) begin
            cnt_nxt[a] = cnt_r[a] + 10'h001;
          end
        end
        AX_WAIT_LOW: begin
          if (!above) begin
            state_nxt[a] = AX_IDLE;
          end
        end
        default: begin
          state_nxt[a] = AX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int a = 0; a < 3; a++) begin
        state_r[a] <= AX_IDLE;
        cnt_r[a] <= 10'h000;
      end
    end else begin
      for (int a = 0; a < 3; a++) begin
        state_r[a] <= state_nxt[a];
        cnt_r[a] <= cnt_nxt[a];
      end
    end
  end

  // Status flags and active bit; a new event always beats a clear
  always_comb begin
    logic [5:0] ev;
    logic clr;
    ev = 6'h00;
    clr = 1'b0;
    for (int a = 0; a < 3; a++) begin
      ev[2 * a] = single_ev[a];
      ev[2 * a + 1] = double_ev[a];
    end
    enabled_ev = |(ev & tap_cfg_r[5:0]);
    if (latch_request) begin
      clr = status_rd;
    end else begin
      clr = active_r && tick && (hold_r <= 10'h001);
    end
    flags_nxt = (clr ? 6'h00 : flags_r) | ev;
    active_nxt = (active_r && !clr) || enabled_ev;
    hold_nxt = hold_r;
    if (enabled_ev) begin
      // Zero latency still holds the line for one tick
      hold_nxt = (lat_r == 8'h00) ? 10'h001 : tgd_ms_ticks(lat_r);
    end else if (tick && hold_r != 10'h000) begin
      hold_nxt = hold_r - 10'h001;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_r <= 6'h00;
      active_r <= 1'b0;
      hold_r <= 10'h000;
    end else begin
      flags_r <= flags_nxt;
      active_r <= active_nxt;
      hold_r <= hold_nxt;
    end
  end

  always_comb begin
    irq_src.wakeup_source_one = wakeup_one_i;
    irq_src.wakeup_source_two = wakeup_two_i;
    irq_src.data_ready = data_ready_i;
    irq_src.tap_irq = active_r;
  end

  tgd_irq_pin u_pin_one (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sel_i(pin_ctrl_r.pin1_source_select),
    .polarity_i(pin_ctrl_r.irq_polarity),
    .drive_i(pin_ctrl_r.irq_drive_type),
    .src_i(irq_src),
    .pin_o(irq_pin_one_o),
    .pin_oe_n_o(irq_pin_one_oe_n_o)
  );

  tgd_irq_pin u_pin_two (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sel_i(pin_ctrl_r.pin2_source_select),
    .polarity_i(pin_ctrl_r.irq_polarity),
    .drive_i(pin_ctrl_r.irq_drive_type),
    .src_i(irq_src),
    .pin_o(irq_pin_two_o),
    .pin_oe_n_o(irq_pin_two_oe_n_o)
  );

endmodule : tgd_top
`default_nettype wire

// ### test/tgd_top_props.sv
// Purpose: Port-level checks of the tap gesture detector.
// Assumes: Registers change only through the write strobe.
// Notes: Tap timing is judged by the bench.
`timescale 1ns/1ps
`default_nettype none
module tgd_top_props #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk_i,              // Clock
  input wire logic reset_n_i,          // Reset, active low
  input wire logic [7:0] reg_addr_i,   // Address
  input wire logic reg_wr_i,           // Write strobe
  input wire logic reg_rd_i,           // Read strobe
  input wire logic [7:0] reg_wdata_i,  // Write data
  input wire logic [7:0] reg_rdata_o,  // Read data
  input wire logic wakeup_one_i,       // Source one
  input wire logic wakeup_two_i,       // Source two
  input wire logic data_ready_i,       // Data ready
  input wire logic irq_pin_one_o,      // Pin one value
  input wire logic irq_pin_one_oe_n_o, // Pin one enable
  input wire logic irq_pin_two_o,      // Pin two value
  input wire logic irq_pin_two_oe_n_o  // Pin two enable
);
  import tgd_pkg::*;
  tgd_pin_ctrl_t ctrl_r, ctrl_d_r;
  logic [7:0] shd_r [8];
  logic [2:0] wk_d_r;
  logic [7:0] exp_rd;
  logic lvl1, lvl2;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  function automatic logic route(logic [2:0] s, logic [2:0] w);
    case (s)
      SEL_WAKE_ONE: return w[0];
      SEL_WAKE_TWO: return w[1];
      SEL_WAKE_ANY: return w[0] | w[1];
      SEL_DATA_READY: return w[2];
      default: return 1'b0;
    endcase
  endfunction : route

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= '0;
    end else if (reg_wr_i && reg_addr_i == ADDR_PIN_CTRL) begin
      ctrl_r <= reg_wdata_i;
    end
  end

  // Reserved bits masked on entry so reads compare directly
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shd_r <= '{default: 8'h00};
    end else if (reg_wr_i && reg_addr_i[7:3] == 5'h07) begin
      shd_r[reg_addr_i[2:0]] <= reg_wdata_i &
        (reg_addr_i == ADDR_THR_Z ? 8'h0f :
         reg_addr_i == ADDR_TAP_CFG ? 8'h7f : 8'hff);
    end
  end

  // Pin flop lags its controls by one cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_d_r <= '0;
      wk_d_r <= '0;
    end else begin
      ctrl_d_r <= ctrl_r;
      wk_d_r <= {data_ready_i, wakeup_two_i, wakeup_one_i};
    end
  end

  always_comb begin
    case (reg_addr_i)
      ADDR_PIN_CTRL: exp_rd = ctrl_r;
      ADDR_TAP_CFG, ADDR_THR_XY, ADDR_THR_Z, ADDR_DUR_LIMIT,
      ADDR_LATENCY, ADDR_WINDOW: exp_rd = shd_r[reg_addr_i[2:0]];
      default: exp_rd = 8'h00;
    endcase
  end

  assign lvl1 = ctrl_d_r.irq_drive_type ? irq_pin_one_oe_n_o : irq_pin_one_o;
  assign lvl2 = ctrl_d_r.irq_drive_type ? irq_pin_two_oe_n_o : irq_pin_two_o;

  sequence s_status_rd;
    reg_rd_i && reg_addr_i == ADDR_TAP_STATUS;
  endsequence
  sequence s_other_rd;
    reg_rd_i && reg_addr_i != ADDR_TAP_STATUS;
  endsequence

  a_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  a_reg_readback: assert property (
    s_other_rd |=> reg_rdata_o == $past(exp_rd))
    else $error("register read back mismatch");
  a_status_top_zero: assert property (
    s_status_rd |=> !reg_rdata_o[7])
    else $error("status bit 7 not zero");
  a_push_pull_drive: assert property (
    !ctrl_d_r.irq_drive_type |-> !irq_pin_one_oe_n_o && !irq_pin_two_oe_n_o)
    else $error("push-pull pin not driven");
  a_open_drain_low: assert property (
    ctrl_d_r.irq_drive_type |-> !irq_pin_one_o && !irq_pin_two_o)
    else $error("open-drain pin value not low");
  a_pin_one_route: assert property (
    ctrl_d_r.pin1_source_select != SEL_TAP |-> lvl1 ==
    (route(ctrl_d_r.pin1_source_select, wk_d_r) ^ ctrl_d_r.irq_polarity))
    else $error("pin one source level wrong");
  a_pin_two_route: assert property (
    ctrl_d_r.pin2_source_select != SEL_TAP |-> lvl2 ==
    (route(ctrl_d_r.pin2_source_select, wk_d_r) ^ ctrl_d_r.irq_polarity))
    else $error("pin two source level wrong");
  a_tap_pin_level: assert property (
    s_status_rd ##0 ctrl_r.pin1_source_select == SEL_TAP |=>
    lvl1 == (reg_rdata_o[6] ^ ctrl_d_r.irq_polarity))
    else $error("tap pin disagrees with active bit");
  a_tap_pin_two: assert property (
    s_status_rd ##0 ctrl_r.pin2_source_select == SEL_TAP |=>
    lvl2 == (reg_rdata_o[6] ^ ctrl_d_r.irq_polarity))
    else $error("pin two disagrees with active bit");
endmodule : tgd_top_props

bind tgd_top tgd_top_props #(.TICK_CYCLES(TICK_CYCLES)) u_tgd_top_props (
  .clk_i, .reset_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .reg_rdata_o, .wakeup_one_i, .wakeup_two_i, .data_ready_i,
  .irq_pin_one_o, .irq_pin_one_oe_n_o, .irq_pin_two_o, .irq_pin_two_oe_n_o
);
`default_nettype wire

// ### test/tgd_host_model.sv
// Purpose: Host side: register accesses and interrupt line levels.
// Assumes: One access at a time, strobes one cycle long.
// Notes: Both interrupt lines carry a board pull-up.
`timescale 1ns/1ps
`default_nettype none
module tgd_host_model (
  input wire logic clk_i,          // System clock
  input wire logic [7:0] rdata_i,  // Read data
  input wire logic pin_one_i,      // Pin one value
  input wire logic pin_one_oe_n_i, // Pin one enable
  input wire logic pin_two_i,      // Pin two value
  input wire logic pin_two_oe_n_i, // Pin two enable
  output logic [7:0] addr_o,       // Address
  output logic wr_o,               // Write strobe
  output logic rd_o,               // Read strobe
  output logic [7:0] wdata_o,      // Write data
  output logic line_one_o,         // Resolved line one
  output logic line_two_o          // Resolved line two
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end

  // Released open drain floats up to the pull-up
  assign line_one_o = pin_one_oe_n_i ? 1'b1 : pin_one_i;
  assign line_two_o = pin_two_oe_n_i ? 1'b1 : pin_two_i;

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask : read_reg
endmodule : tgd_host_model
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench for the tap gesture detector.
// Assumes: Short tick of 4 clocks so tap timing stays brief.
// Notes: Tap windows carry a few cycles of margin for tick phase.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tgd_pkg::*;
  localparam logic [7:0] AD [9] = '{8'h22, 8'h38, 8'h3b, 8'h3c, 8'h3d,
    8'h3e, 8'h3f, 8'h39, 8'h30};
  localparam logic [7:0] EX [9] = '{8'hff, 8'h7f, 8'hff, 8'h0f, 8'hff,
    8'hff, 8'hff, 8'h00, 8'h00};
  logic clk;
  logic reset_n = 1'b0;
  tgd_accel_t accel = '0;
  logic w1 = 1'b0;
  logic w2 = 1'b0;
  logic dr = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, p1, p1_oe_n, p2, p2_oe_n, line1, line2;
  int bad_count = 0;
  int samples_checked = 0;

  tgd_top #(.TICK_CYCLES(4)) u_tgd_top (.clk_i(clk), .reset_n_i(reset_n),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .accel_i(accel), .wakeup_one_i(w1),
    .wakeup_two_i(w2), .data_ready_i(dr), .irq_pin_one_o(p1),
    .irq_pin_one_oe_n_o(p1_oe_n), .irq_pin_two_o(p2),
    .irq_pin_two_oe_n_o(p2_oe_n));
  tgd_host_model u_tgd_host_model (.clk_i(clk), .rdata_i(rdata),
    .pin_one_i(p1), .pin_one_oe_n_i(p1_oe_n), .pin_two_i(p2),
    .pin_two_oe_n_i(p2_oe_n), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata), .line_one_o(line1), .line_two_o(line2));

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic do_reset();
    reset_n <= 1'b0;
    cyc(6);
    reset_n <= 1'b1;
  endtask : do_reset

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    u_tgd_host_model.write_reg(a, d);
  endtask : wreg

  task automatic check_status(input logic [7:0] e);
    logic [7:0] d;
    u_tgd_host_model.read_reg(ADDR_TAP_STATUS, d);
    chk(e, d);
  endtask : check_status

  task automatic lines(input logic e1, input logic e2);
    @(negedge clk);
    chk({7'h0, e1}, {7'h0, line1});
    chk({7'h0, e2}, {7'h0, line2});
  endtask : lines

  task automatic tap(input tgd_accel_t a, input int hi);
    @(posedge clk);
    accel <= a;
    cyc(hi);
    accel <= '0;
  endtask : tap

  task automatic test_regs();
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      u_tgd_host_model.read_reg(AD[i], d);
      chk(8'h00, d);
      wreg(AD[i], 8'hff);
    end
    for (int i = 0; i < 9; i++) begin
      u_tgd_host_model.read_reg(AD[i], d);
      chk(EX[i], d);
    end
    // Realign to a rising edge before pulling reset
    cyc(1);
    do_reset();
    for (int i = 0; i < 9; i++) begin
      u_tgd_host_model.read_reg(AD[i], d);
      chk(8'h00, d);
    end
  endtask : test_regs

  task automatic test_pins();
    logic [2:0] pat [2] = '{3'b101, 3'b010};
    logic e;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 7; s++) begin
        for (int p = 0; p < 2; p++) begin
          @(posedge clk);
          {dr, w2, w1} <= pat[p];
          wreg(ADDR_PIN_CTRL, {m[1:0], s[2:0], s[2:0]});
          case (s)
            1: e = pat[p][0];
            2: e = pat[p][1];
            3: e = pat[p][0] | pat[p][1];
            4: e = pat[p][2];
            default: e = 1'b0;
          endcase
          cyc(1);
          lines(e ^ m[1], e ^ m[1]);
        end
      end
    end
  endtask : test_pins

  task automatic sgl_case(input tgd_accel_t a, input int hi,
                          input logic [7:0] e);
    tap(a, hi);
    cyc(3);
    check_status(e);
    lines(e[6], 1'b0);
    cyc(45);
    check_status(8'h00);
    lines(1'b0, 1'b0);
  endtask : sgl_case

  task automatic test_single();
    wreg(ADDR_PIN_CTRL, 8'h07);
    wreg(ADDR_TAP_CFG, 8'h15);
    wreg(ADDR_THR_XY, 8'h21);
    wreg(ADDR_THR_Z, 8'h03);
    wreg(ADDR_DUR_LIMIT, 8'h08);
    wreg(ADDR_LATENCY, 8'h04);
    sgl_case(24'h00_0010, 6, 8'h00);
    sgl_case(24'h00_0011, 6, 8'h41);
    sgl_case(24'h00_2000, 6, 8'h00);
    sgl_case(24'h00_2100, 6, 8'h44);
    sgl_case(24'h30_0000, 6, 8'h00);
    sgl_case(24'h31_0000, 6, 8'h50);
    sgl_case(24'h00_00c8, 50, 8'h00);
    sgl_case(24'h00_00c8, 24, 8'h41);
  endtask : test_single

  task automatic test_latch();
    wreg(ADDR_TAP_CFG, 8'h51);
    tap(24'h31_0000, 6);
    cyc(60);
    lines(1'b1, 1'b0);
    check_status(8'h50);
    check_status(8'h00);
    lines(1'b0, 1'b0);
    tap(24'h00_2100, 6);
    cyc(5);
    check_status(8'h04);
    check_status(8'h00);
  endtask : test_latch

  task automatic dbl_case(input int gap, input int hi2, input logic [7:0] e);
    tap(24'h00_0028, 6);
    cyc(gap);
    tap(24'h00_0028, hi2);
    cyc(80);
    lines(~e[6], ~e[6]);
    check_status(e);
    check_status(8'h00);
  endtask : dbl_case

  task automatic test_double();
    // Both pins on tap, active low, open drain
    wreg(ADDR_PIN_CTRL, 8'hff);
    wreg(ADDR_TAP_CFG, 8'h42);
    wreg(ADDR_LATENCY, 8'h02);
    wreg(ADDR_WINDOW, 8'h04);
    dbl_case(24, 6, 8'h43);
    dbl_case(4, 4, 8'h01);
    dbl_case(70, 6, 8'h01);
    dbl_case(4, 20, 8'h43);
  endtask : test_double

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    do_reset();
    test_regs();
    test_pins();
    test_single();
    test_latch();
    test_double();
    wrap_up();
  end

  // Whole run needs about 1500 clocks
  initial begin
    #400_000;
    bad_count++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
